// ==== hdl/fpsq_chan.sv ====
// Purpose: One channel turn-on delay, ramp up, turn-off delay, ramp down
// Assumes: Timing counts are stable while the channel is busy
// Notes:   A dropped request mid-ramp reverses into a controlled ramp down
`default_nettype none

module fpsq_chan (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    input  wire logic                  ce,
    // Request and timing
    input  wire logic                  req,
    input  wire logic [fpsq_pkg::CW-1:0] t_on,
    input  wire logic [fpsq_pkg::CW-1:0] t_off,
    input  wire logic [fpsq_pkg::CW-1:0] t_ramp,
    // Channel state
    output var  logic                  gate_o,
    output var  logic                  full_on_o,
    output var  logic                  is_off_o
);
    import fpsq_pkg::*;

    fpsq_chst_t    st_r;
    fpsq_chst_t    st_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] lim;
    logic          hit;

    always_comb begin
        case (st_r)
            CH_WON:  lim = t_on;
            CH_WOFF: lim = t_off;
            default: lim = t_ramp;
        endcase
    end
    assign hit = (cnt_r >= lim);

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            CH_OFF:  if (req) st_nxt = CH_WON;
            CH_WON:  if (!req) st_nxt = CH_OFF; else if (hit) st_nxt = CH_RISE;
            CH_RISE: if (!req) st_nxt = CH_FALL; else if (hit) st_nxt = CH_ON;
            CH_ON:   if (!req) st_nxt = CH_WOFF;
            CH_WOFF: if (req) st_nxt = CH_ON; else if (hit) st_nxt = CH_FALL;
            CH_FALL: if (hit) st_nxt = CH_OFF;
            default: st_nxt = CH_OFF;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r      <= CH_OFF;
            cnt_r     <= '0;
            gate_o    <= 1'b0;
            full_on_o <= 1'b0;
            is_off_o  <= 1'b1;
        end else if (ce) begin
            st_r      <= st_nxt;
            cnt_r     <= (st_nxt != st_r) ? '0 : cnt_r + CW'(1);
            gate_o    <= st_nxt inside {CH_RISE, CH_ON, CH_WOFF};
            full_on_o <= st_nxt inside {CH_ON, CH_WOFF};
            is_off_o  <= st_nxt inside {CH_OFF, CH_WON};
        end
    end

endmodule

`default_nettype wire

// ==== hdl/fpsq_filt.sv ====
// Purpose: Two-stage synchroniser plus symmetric glitch filter for one pin
// Assumes: din is asynchronous to clk_sys
// Notes:   Output follows only after FILT cycles of steady disagreement
`default_nettype none

module fpsq_filt #(
    parameter int unsigned FILT = 1
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic ce,
    // Pin and filtered level
    input  wire logic din,
    output var  logic dout
);
    import fpsq_pkg::*;

    localparam int          FW   = (FILT < 2) ? 1 : $clog2(FILT);
    localparam logic [FW-1:0] LAST = FW'(FILT - 1);

    if (FILT < 1) begin : g_chk
        $error("fpsq_filt: FILT must be at least one");
    end

    logic          sync1_r;
    logic          sync2_r;
    logic [FW-1:0] cnt_r;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else if (ce) begin
            sync1_r <= din;
            sync2_r <= sync1_r;
        end
    end

    // Dips shorter than the window never reach dout
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
            dout  <= 1'b0;
        end else if (ce) begin
            if (sync2_r == dout) begin
                cnt_r <= '0;
            end else if (cnt_r == LAST) begin
                cnt_r <= '0;
                dout  <= sync2_r;
            end else begin
                cnt_r <= cnt_r + FW'(1);
            end
        end
    end

    AST_FILT_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ce && sync2_r != dout && cnt_r != LAST) |=> dout == $past(dout))
        else $error("filtered level moved before the window elapsed");

endmodule

`default_nettype wire

// ==== hdl/fpsq_pkg.sv ====
// Purpose: Shared constants and types of the four rail power sequencer
// Assumes: clk_sys at 100 MHz
// Notes:   Times kept in their own units, cycle counts derived from them
`default_nettype none

package fpsq_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ   = 100;
    localparam int unsigned FILT_US   = 30;
    localparam int unsigned FILT_CYC  = FILT_US * CLK_MHZ;
    localparam int unsigned BLANK_MS  = 10;
    localparam int unsigned BLANK_CYC = BLANK_MS * 1000 * CLK_MHZ;
    localparam int unsigned RDY_MS    = 150;
    localparam int unsigned RDY_CYC   = RDY_MS * 1000 * CLK_MHZ;

    // ------------------------------------------------------------
    // Sizes and register map
    // ------------------------------------------------------------
    localparam int          NCH       = 4;
    localparam int          AW        = 8;
    localparam int          DW        = 32;
    localparam int          CW        = 16;
    localparam logic [7:0]  REG_CTRL  = 8'h00;
    localparam logic [7:0]  REG_STAT  = 8'h01;
    localparam logic [7:0]  REG_IRQ   = 8'h02;
    localparam logic [7:0]  REG_MASK  = 8'h03;
    localparam logic [3:0]  TIM_PAGE  = 4'h1;
    localparam logic [1:0]  TIM_ON    = 2'h0;
    localparam logic [1:0]  TIM_OFF   = 2'h1;
    localparam logic [1:0]  TIM_RAMP  = 2'h2;
    localparam logic [15:0] TIM_RST   = 16'h0064;
    localparam logic [3:0]  CTRL_RST  = 4'h0;
    localparam int          CTRL_POL  = 2;
    localparam int          CTRL_STBY = 3;
    localparam int          NIRQ      = 4;
    localparam int          IRQ_RDY1  = 0;
    localparam int          IRQ_RDY2  = 1;
    localparam int          IRQ_FAULT = 2;
    localparam int          IRQ_CHAIN = 3;

    typedef enum logic [1:0] {FPSQ_ALL, FPSQ_INDEP, FPSQ_FIXED, FPSQ_GROUP} fpsq_mode_t;
    typedef enum logic [2:0] {CH_OFF, CH_WON, CH_RISE, CH_ON, CH_WOFF, CH_FALL} fpsq_chst_t;

endpackage

`default_nettype wire

// ==== hdl/fpsq_top.sv ====
// Purpose: Four rail power sequencer with mode select, ready and cascade
// Assumes: Pins asynchronous; register port synchronous to clk_sys
// Notes:   Rails default to all-rails-required mode after reset
// Operation
// - Fixed order turns rails on A-B-C-D, off D-C-B-A.
// - Fixed order: next rail starts only after previous ramp completes.
// - Fixed order starts only with all rails compliant and enable asserted.
// - Independent mode: each rail follows only its own compliance; code pulls the chain low unless all four comply, stopping every rail.
// - All-rails mode: no turn-on until all four rails compliant.
// - All-rails mode: loss of any rail while on is a fault.
// - Grouped mode: two pairs, each with own enable and ready.
// - Grouped mode needs all four first; group faults stay local; code pulls the chain low on any rail loss, stopping both pairs.
// - Cascaded devices share one wired chain line, driven and sensed.
// - Enable polarity selectable, high or low active.
// - Standby while enable deasserted, left when enable returns.
// - Ready output reports all controlled rails turned on.
// - Enable ignored for 10 ms after compliance first satisfied.
// - Ready asserts 150 ms after all gates fully on.
// - Ready drops at once on compliance loss or enable removal.
// - Compliance dips under 30 us are filtered out.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`default_nettype none

module fpsq_top #(
    parameter int unsigned BLANK_CYC = fpsq_pkg::BLANK_CYC,
    parameter int unsigned RDY_CYC   = fpsq_pkg::RDY_CYC
) (
    // Clock, reset, enable
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    input  wire logic                  ce,
    // Register port
    input  wire logic [fpsq_pkg::AW-1:0] reg_addr,
    input  wire logic [fpsq_pkg::DW-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output var  logic [fpsq_pkg::DW-1:0] reg_rdata,
    // Rail compliance pins
    input  wire logic                  rail_a_compliance_in,
    input  wire logic                  rail_b_compliance_in,
    input  wire logic                  rail_c_compliance_in,
    input  wire logic                  rail_d_compliance_in,
    // Enable pins
    input  wire logic                  enable_1_in,
    input  wire logic                  enable_2_in,
    // Gate drives
    output var  logic [fpsq_pkg::NCH-1:0] gate_o,
    // Ready and standby
    output var  logic                  ready_1_o,
    output var  logic                  ready_2_o,
    output var  logic                  standby_o,
    // Cascade line, open drain
    input  wire logic                  cascade_chain_line_i,
    output var  logic                  cascade_chain_line_o,
    output var  logic                  cascade_chain_line_oe,
    // Interrupt
    output var  logic                  irq_o
);
    import fpsq_pkg::*;

    // Blanking below two cycles cannot hold the enable off long enough
    if (BLANK_CYC < 2 || RDY_CYC < 1) begin : g_chk
        $error("fpsq_top: blank count must be at least two, ready count at least one");
    end

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    logic [NCH-1:0] comp_pin;
    logic [NCH-1:0] comp;
    logic [1:0]     en_pin;
    logic [1:0]     en_f;
    logic           chain_f;

    assign comp_pin = {rail_d_compliance_in, rail_c_compliance_in,
                       rail_b_compliance_in, rail_a_compliance_in};
    assign en_pin   = {enable_2_in, enable_1_in};

    for (genvar i = 0; i < NCH; i++) begin : g_cf
        fpsq_filt #(.FILT(FILT_CYC)) u_filt (
            .clk_sys (clk_sys),
            .rst_b   (rst_b),
            .ce      (ce),
            .din     (comp_pin[i]),
            .dout    (comp[i])
        );
    end

    for (genvar k = 0; k < 2; k++) begin : g_ef
        fpsq_filt #(.FILT(1)) u_filt (
            .clk_sys (clk_sys),
            .rst_b   (rst_b),
            .ce      (ce),
            .din     (en_pin[k]),
            .dout    (en_f[k])
        );
    end

    fpsq_filt #(.FILT(1)) u_chain (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .ce      (ce),
        .din     (cascade_chain_line_i),
        .dout    (chain_f)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [3:0]      ctrl_r;
    logic [NIRQ-1:0] irq_stat_r;
    logic [NIRQ-1:0] irq_mask_r;
    logic [NIRQ-1:0] ev;
    logic [CW-1:0]   t_on_r   [NCH];
    logic [CW-1:0]   t_off_r  [NCH];
    logic [CW-1:0]   t_ramp_r [NCH];
    logic            tim_sel;
    logic [1:0]      tim_ch;
    logic [1:0]      tim_fld;
    fpsq_mode_t      mode;

    assign mode    = fpsq_mode_t'(ctrl_r[1:0]);
    assign tim_sel = (reg_addr[7:4] == TIM_PAGE);
    assign tim_ch  = reg_addr[3:2];
    assign tim_fld = reg_addr[1:0];

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r     <= CTRL_RST;
            irq_mask_r <= '0;
        end else if (ce && reg_wr) begin
            if (reg_addr == REG_CTRL) ctrl_r <= reg_wdata[3:0];
            if (reg_addr == REG_MASK) irq_mask_r <= reg_wdata[NIRQ-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NCH; i++) begin
                t_on_r[i]   <= TIM_RST;
                t_off_r[i]  <= TIM_RST;
                t_ramp_r[i] <= TIM_RST;
            end
        end else if (ce && reg_wr && tim_sel) begin
            case (tim_fld)
                TIM_ON:   t_on_r[tim_ch]   <= reg_wdata[CW-1:0];
                TIM_OFF:  t_off_r[tim_ch]  <= reg_wdata[CW-1:0];
                TIM_RAMP: t_ramp_r[tim_ch] <= reg_wdata[CW-1:0];
                default:  ;
            endcase
        end
    end

    // Set beats the clear-on-read in the same cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_r <= '0;
        end else if (ce) begin
            irq_stat_r <= ((reg_rd && reg_addr == REG_IRQ) ? '0 : irq_stat_r) | ev;
        end
    end

    // ------------------------------------------------------------
    // Enable qualification
    // ------------------------------------------------------------
    logic [1:0]     en_lvl;
    logic [1:0]     en_ok;
    logic           all_comp;
    logic           all_comp_q_r;
    logic [31:0]    blank_cnt_r;
    logic           blank_act;
    logic           armed_r;
    logic           start;
    logic [NCH-1:0] gate;
    logic [NCH-1:0] full_on;
    logic [NCH-1:0] is_off;

    assign all_comp  = &comp;
    assign blank_act = (blank_cnt_r != '0);
    // Second enable pin matters only when the rails are split in pairs
    assign en_lvl[0] = en_f[0] ^ ctrl_r[CTRL_POL];
    assign en_lvl[1] = ((mode == FPSQ_GROUP) ? en_f[1] : en_f[0]) ^ ctrl_r[CTRL_POL];
    assign en_ok     = blank_act ? 2'b00 : en_lvl;
    assign start     = all_comp && en_ok[0] && chain_f;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            all_comp_q_r <= 1'b0;
            blank_cnt_r  <= '0;
        end else if (ce) begin
            all_comp_q_r <= all_comp;
            if (all_comp && !all_comp_q_r) begin
                blank_cnt_r <= BLANK_CYC;
            end else if (blank_act) begin
                blank_cnt_r <= blank_cnt_r - 32'h0000_0001;
            end
        end
    end

    // Arming survives a single group fault; the healthy pair still drops when the fault pulls chain_f low
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            armed_r <= 1'b0;
        end else if (ce) begin
            if (all_comp) begin
                armed_r <= 1'b1;
            end else if (&is_off) begin
                armed_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Channel requests
    // ------------------------------------------------------------
    logic [NCH-1:0] req;
    logic [NCH-1:0] prev_full;
    logic [NCH-1:0] next_off;

    assign prev_full = {full_on[NCH-2:0], 1'b1};
    assign next_off  = {1'b1, is_off[NCH-1:1]};

    always_comb begin
        req = '0;
        for (int i = 0; i < NCH; i++) begin
            case (mode)
                FPSQ_ALL:   req[i] = all_comp && en_ok[0] && chain_f;
                FPSQ_INDEP: req[i] = comp[i] && en_ok[0] && chain_f;
                FPSQ_FIXED: req[i] = (start && prev_full[i])
                                     || (gate[i] && !next_off[i]);
                FPSQ_GROUP: req[i] = armed_r && en_ok[i/2] && chain_f
                                     && (&comp[(i/2)*2 +: 2]);
                default:    req[i] = 1'b0;
            endcase
        end
    end

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        fpsq_chan u_chan (
            .clk_sys   (clk_sys),
            .rst_b     (rst_b),
            .ce        (ce),
            .req       (req[i]),
            .t_on      (t_on_r[i]),
            .t_off     (t_off_r[i]),
            .t_ramp    (t_ramp_r[i]),
            .gate_o    (gate[i]),
            .full_on_o (full_on[i]),
            .is_off_o  (is_off[i])
        );
    end
    assign gate_o = gate;

    // ------------------------------------------------------------
    // Ready per group
    // ------------------------------------------------------------
    logic [NCH-1:0] grp_mask [2];
    logic [1:0]     done;
    logic [31:0]    rdy_cnt_r [2];
    logic [1:0]     rdy_r;

    always_comb begin
        grp_mask[0] = (mode == FPSQ_GROUP) ? 4'h3 : 4'hF;
        grp_mask[1] = (mode == FPSQ_GROUP) ? 4'hC : 4'hF;
        for (int g = 0; g < 2; g++) begin
            done[g] = (&(full_on | ~grp_mask[g])) && (&(comp | ~grp_mask[g]))
                      && en_lvl[g] && chain_f;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdy_cnt_r[0] <= '0;
            rdy_cnt_r[1] <= '0;
            rdy_r        <= 2'b00;
        end else if (ce) begin
            for (int g = 0; g < 2; g++) begin
                if (!done[g]) begin
                    rdy_cnt_r[g] <= '0;
                    rdy_r[g]     <= 1'b0;
                end else if (rdy_cnt_r[g] == RDY_CYC) begin
                    rdy_r[g]     <= 1'b1;
                end else begin
                    rdy_cnt_r[g] <= rdy_cnt_r[g] + 32'h0000_0001;
                end
            end
        end
    end
    assign ready_1_o = rdy_r[0];
    assign ready_2_o = rdy_r[1];

    // ------------------------------------------------------------
    // Standby, cascade line, events
    // ------------------------------------------------------------
    logic [NCH-1:0] comp_q_r;
    logic [1:0]     rdy_q_r;
    logic           chain_q_r;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            standby_o             <= 1'b0;
            cascade_chain_line_oe <= 1'b1;
        end else if (ce) begin
            standby_o <= ctrl_r[CTRL_STBY] && !en_lvl[0] && (&is_off);
            // Hold the whole chain off until every local rail is good
            cascade_chain_line_oe <= !all_comp;
        end
    end
    assign cascade_chain_line_o = 1'b0;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            comp_q_r  <= '0;
            rdy_q_r   <= 2'b00;
            chain_q_r <= 1'b0;
        end else if (ce) begin
            comp_q_r  <= comp;
            rdy_q_r   <= rdy_r;
            chain_q_r <= chain_f;
        end
    end

    always_comb begin
        ev            = '0;
        ev[IRQ_RDY1]  = ce && rdy_r[0] && !rdy_q_r[0];
        ev[IRQ_RDY2]  = ce && rdy_r[1] && !rdy_q_r[1];
        ev[IRQ_FAULT] = ce && (|(gate & comp_q_r & ~comp));
        ev[IRQ_CHAIN] = ce && chain_q_r && !chain_f;
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [DW-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        if (reg_addr == REG_CTRL) begin
            rd_mux[3:0] = ctrl_r;
        end else if (reg_addr == REG_STAT) begin
            rd_mux[15:0] = {chain_f, standby_o, comp, rdy_r, full_on, gate};
        end else if (reg_addr == REG_IRQ) begin
            rd_mux[NIRQ-1:0] = irq_stat_r;
        end else if (reg_addr == REG_MASK) begin
            rd_mux[NIRQ-1:0] = irq_mask_r;
        end else if (tim_sel && tim_fld == TIM_ON) begin
            rd_mux[CW-1:0] = t_on_r[tim_ch];
        end else if (tim_sel && tim_fld == TIM_OFF) begin
            rd_mux[CW-1:0] = t_off_r[tim_ch];
        end else if (tim_sel && tim_fld == TIM_RAMP) begin
            rd_mux[CW-1:0] = t_ramp_r[tim_ch];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    AST_FIX_ON_ORDER: assert property (
        (mode == FPSQ_FIXED && gate[1] && !$past(gate[1])) |-> $past(full_on[0]))
        else $error("rail B started before rail A finished its ramp");

    AST_FIX_OFF_ORDER: assert property (
        (mode == FPSQ_FIXED && !gate[2] && $past(gate[2])) |-> is_off[3])
        else $error("rail C went off while rail D was still on");

    AST_FIX_START: assert property (
        (mode == FPSQ_FIXED && ce && is_off[0] && !start) |=> is_off[0])
        else $error("fixed order left idle without start condition");

    AST_INDEP_OWN: assert property (
        (mode == FPSQ_INDEP && ce && is_off[3] && !comp[3]) |=> is_off[3])
        else $error("rail D armed without its own compliance");

    AST_ALL_BLOCK: assert property (
        (mode == FPSQ_ALL && ce && !all_comp) |-> req == 4'h0)
        else $error("request raised without all rails compliant");

    AST_GRP_ISOLATE: assert property (
        (mode == FPSQ_GROUP && armed_r && en_ok[0] && chain_f && (&comp[1:0]))
        |-> req[1:0] == 2'b11)
        else $error("pair A-B disturbed by the other group");

    AST_RDY_DELAY: assert property (
        (rdy_r[0] && !$past(rdy_r[0])) |-> $past(rdy_cnt_r[0]) == RDY_CYC)
        else $error("ready rose without the settle delay");

    AST_RDY_DROP: assert property (
        (ce && rdy_r[0] && !done[0]) |=> !rdy_r[0])
        else $error("ready held after loss of compliance or enable");

    AST_BLANK: assert property (
        (ce && all_comp && !all_comp_q_r) |=> blank_act [*2])
        else $error("enable not ignored after compliance came up");

    AST_STBY: assert property (
        standby_o |-> $past(!en_lvl[0]))
        else $error("standby shown while enabled");

    CVR_FIX_READY: cover property (mode == FPSQ_FIXED && rdy_r[0]);
    CVR_GRP_SPLIT: cover property (mode == FPSQ_GROUP && rdy_r[1] && !rdy_r[0]);
    CVR_FAULT: cover property (ev[IRQ_FAULT] && mode == FPSQ_ALL);

endmodule

`default_nettype wire

// ==== testbench/fpsq_rails.sv ====
// Purpose: Supply rails and wired chain seen by the sequencer
// Assumes: Rails reach compliance when commanded up
// Notes:   Chain line floats high unless a device pulls it
`default_nettype none
module fpsq_rails (
    // Command
    input  wire logic       up,
    // Sequencer side
    input  wire logic       chain_o,
    input  wire logic       chain_oe,
    output var  logic [3:0] comp,
    output var  logic       chain_i
);
    timeunit 1ns;
    timeprecision 1ns;
    always_comb comp = {4{up}};
    always_comb chain_i = chain_oe ? chain_o : 1'b1;
endmodule
`default_nettype wire

// ==== testbench/test_fpsq_top.sv ====
// Purpose: Fixed order sequencing, ready, interrupt and register checks
// Assumes: Short blank and ready counts
// Notes:   Waits on gates are bounded, a stall reads as a mismatch
`default_nettype none
module test_fpsq_top;
    timeunit 1ns;
    timeprecision 1ns;
    import fpsq_pkg::*;
    logic        clk_sys, rst_b, reg_wr, reg_rd, up, en, ch_o, ch_oe, ch_i;
    logic        rdy1, rdy2, stby, irq_o;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [3:0]  comp, gate_o;
    int          err_total, checked, cyc;
    fpsq_top #(.BLANK_CYC(20), .RDY_CYC(20)) fpsq_top_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rail_a_compliance_in(comp[0]),
        .rail_b_compliance_in(comp[1]), .rail_c_compliance_in(comp[2]),
        .rail_d_compliance_in(comp[3]), .enable_1_in(en), .enable_2_in(1'b0),
        .gate_o(gate_o), .ready_1_o(rdy1), .ready_2_o(rdy2), .standby_o(stby),
        .cascade_chain_line_i(ch_i), .cascade_chain_line_o(ch_o),
        .cascade_chain_line_oe(ch_oe), .irq_o(irq_o));
    fpsq_rails fpsq_rails_i (.up(up), .chain_o(ch_o), .chain_oe(ch_oe), .comp(comp),
        .chain_i(ch_i));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic print_verdict();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    // Gate pattern must appear within a bounded wait
    task automatic wait_gate(input logic [3:0] g);
        for (int n = 0; n < 600 && gate_o !== g; n++) @(negedge clk_sys);
        chk("gate_o", 32'(g), 32'(gate_o));
    endtask
    initial begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        up = 1'b0;
        en = 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(8'h10);
        chk("on_delay", 32'(TIM_RST), d);
        rd(8'h40);
        chk("unmapped", 32'h0, d);
        wr(REG_MASK, 32'h1);
        wr(REG_CTRL, 32'h2);
        up <= 1'b1;
        repeat (3200) @(posedge clk_sys);
        chk("gate_o", 32'h0, 32'(gate_o));
        chk("chain_oe", 32'h0, 32'(ch_oe));
        chk("standby_o", 32'h0, 32'(stby));
        en <= 1'b1;
        wait_gate(4'h1);
        wait_gate(4'h3);
        wait_gate(4'h7);
        wait_gate(4'hF);
        for (int n = 0; n < 600 && rdy1 !== 1'b1; n++) @(negedge clk_sys);
        chk("ready_1_o", 32'h1, 32'(rdy1));
        chk("ready_2_o", 32'h1, 32'(rdy2));
        rd(REG_STAT);
        chk("status", 32'h0000_BFFF, d);
        chk("irq_o", 32'h1, 32'(irq_o));
        rd(REG_IRQ);
        chk("irq_stat", 32'h1, d & 32'h1);
        rd(REG_IRQ);
        chk("irq_stat", 32'h0, d & 32'h1);
        chk("irq_o", 32'h0, 32'(irq_o));
        $display("test fixed_on done");
        en <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk("ready_1_o", 32'h0, 32'(rdy1));
        wait_gate(4'h7);
        wait_gate(4'h3);
        wait_gate(4'h1);
        wait_gate(4'h0);
        $display("test fixed_off done");
        wr(REG_CTRL, 32'h1);
        en <= 1'b1;
        wait_gate(4'hF);
        $display("test indep_on done");
        print_verdict();
    end
endmodule
`default_nettype wire
